// [hw/mciu_axil_slave.sv]
// axi4-lite slave front end: one write and one read at a time
`default_nettype none
module mciu_axil_slave (
	input wire logic aclk, // system clock
	input wire logic aresetn, // synchronous reset, active low
	input wire logic [mciu_pkg::ADDR_W-1:0] awaddr, // write address
	input wire logic awvalid, // write address valid
	output logic awready, // write address ready
	input wire logic [mciu_pkg::DATA_W-1:0] wdata, // write data
	input wire logic [mciu_pkg::DATA_W/8-1:0] wstrb, // write strobes
	input wire logic wvalid, // write data valid
	output logic wready, // write data ready
	output logic [1:0] bresp, // write response
	output logic bvalid, // write response valid
	input wire logic bready, // write response ready
	input wire logic [mciu_pkg::ADDR_W-1:0] araddr, // read address
	input wire logic arvalid, // read address valid
	output logic arready, // read address ready
	output logic [mciu_pkg::DATA_W-1:0] rdata, // read data
	output logic [1:0] rresp, // read response
	output logic rvalid, // read data valid
	input wire logic rready, // read data ready
	output logic wr_en, // one-cycle register write strobe
	output mciu_pkg::mciu_wr_t wr, // register write payload
	input wire logic wr_hit, // write address is mapped
	input wire logic [mciu_pkg::DATA_W-1:0] rd_data, // read value at araddr
	input wire logic rd_hit // read address is mapped
);
	logic aw_held;
	logic w_held;
	logic [mciu_pkg::ADDR_W-1:0] aw_addr;
	logic [mciu_pkg::DATA_W-1:0] w_data;
	logic [mciu_pkg::DATA_W/8-1:0] w_strb;

	// no new write is taken while a response waits, so one write at a time
	assign awready = !aw_held && !bvalid;
	assign wready = !w_held && !bvalid;
	assign wr_en = aw_held && w_held && !bvalid;
	assign wr = '{addr: aw_addr, data: w_data, strb: w_strb};
	assign arready = !rvalid;

	// address and data arrive in either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
		end
		else if (wr_en)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= awaddr;
			end
			if (wvalid && wready)
			begin
				w_held <= 1'b1;
				w_data <= wdata;
				w_strb <= wstrb;
			end
		end
	end

	// write response
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid <= 1'b0;
			bresp <= mciu_pkg::RESP_OKAY;
		end
		else if (wr_en)
		begin
			bvalid <= 1'b1;
			bresp <= wr_hit ? mciu_pkg::RESP_OKAY : mciu_pkg::RESP_SLVERR;
		end
		else if (bready)
			bvalid <= 1'b0;
	end

	// read answers one cycle after the address is taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= mciu_pkg::RESP_OKAY;
		end
		else if (arvalid && arready)
		begin
			rvalid <= 1'b1;
			rdata <= rd_hit ? rd_data : '0;
			rresp <= rd_hit ? mciu_pkg::RESP_OKAY : mciu_pkg::RESP_SLVERR;
		end
		else if (rready)
			rvalid <= 1'b0;
	end
endmodule : mciu_axil_slave
`default_nettype wire

// [hw/mciu_dummy_never.sv]
// holds no logic

// [hw/mciu_edge_det.sv]
// two-stage synchroniser with rise and fall detection per bit
`default_nettype none
module mciu_edge_det #(
	parameter int unsigned W = 1
) (
	input wire logic aclk, // system clock
	input wire logic aresetn, // synchronous reset, active low
	input wire logic [W-1:0] pin, // asynchronous pin levels
	output logic [W-1:0] rise, // one-cycle rising pulse per bit
	output logic [W-1:0] fall // one-cycle falling pulse per bit
);
	logic [W-1:0] meta;
	logic [W-1:0] stable;
	logic [W-1:0] prev;
	logic primed;

	// meta is read only by stable; unreset, so a level held in reset gives no edge
	always_ff @(posedge aclk)
	begin
		meta <= pin;
		stable <= meta;
		prev <= stable;
	end

	// primed blocks an edge in the first cycle after reset
	always_ff @(posedge aclk)
	begin
		primed <= aresetn;
	end

	assign rise = primed ? (stable & ~prev) : '0;
	assign fall = primed ? (~stable & prev) : '0;
endmodule : mciu_edge_det
`default_nettype wire

// [hw/mciu_pkg.sv]
// shared constants, register map and carrier types of the interrupt unit
`default_nettype none
package mciu_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned PC_W = 13;
	localparam int unsigned REG_W = 8;
	localparam int unsigned PORT_W = 4;
	// register byte offsets on the bus
	localparam logic [ADDR_W-1:0] OFS_IRQ_CONTROL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_OPTION = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_NVM_CONTROL = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_CORE_STATE = 8'h14;
	// irq_control field positions
	localparam int unsigned BIT_GLOBAL_EN = 7;
	localparam int unsigned BIT_NVM_EN = 6;
	localparam int unsigned BIT_TIMER_EN = 5;
	localparam int unsigned BIT_EXT_EN = 4;
	localparam int unsigned BIT_PORT_EN = 3;
	localparam int unsigned BIT_TIMER_FLAG = 2;
	localparam int unsigned BIT_EXT_FLAG = 1;
	localparam int unsigned BIT_PORT_FLAG = 0;
	// option and nvm control field positions
	localparam int unsigned BIT_EDGE_SEL = 6;
	localparam int unsigned BIT_NVM_FLAG = 4;
	// reset values, nvm control write mask and vector address
	localparam logic [REG_W-1:0] IRQ_CONTROL_RST = 8'h00;
	localparam logic [REG_W-1:0] OPTION_RST = 8'hFF;
	localparam logic [REG_W-1:0] NVM_CONTROL_RST = 8'h00;
	localparam logic [REG_W-1:0] NVM_CONTROL_MASK = 8'h10;
	localparam logic [PC_W-1:0] VECTOR_PC = 13'h0004;
	localparam logic [PC_W-1:0] PC_RST = 13'h0000;
	// wrapper event bits in irq_status and irq_mask
	localparam int unsigned EVT_W = 3;
	localparam int unsigned EVT_VECTOR = 0;
	localparam int unsigned EVT_WAKE = 1;
	localparam int unsigned EVT_SLEEP_NOP = 2;
	localparam logic [EVT_W-1:0] EVT_RST = 3'h0;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0]
	{
		ST_RUN = 2'h0,
		ST_ARMED = 2'h1,
		ST_SWITCH = 2'h3,
		ST_SLEEP = 2'h2
	} mciu_state_t;

	typedef struct packed
	{
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [DATA_W/8-1:0] strb;
	} mciu_wr_t;

	typedef struct packed
	{
		logic cycle_tick;
		logic handler_return;
		logic sleep_enter;
		logic [PC_W-1:0] return_pc;
	} mciu_core_in_t;

	typedef struct packed
	{
		logic vector_load;
		logic [PC_W-1:0] vector_pc;
		logic stack_push;
		logic [PC_W-1:0] stack_data;
		logic wake;
		logic asleep;
	} mciu_core_out_t;
endpackage : mciu_pkg
`default_nettype wire

// [hw/mciu_top.sv]
// interrupt unit of a small microcontroller: flags, enables, vectoring and wake
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`default_nettype none
// Overview of operation
// - exactly four sources: edge pin, timer wrap, upper port change, nvm write done
// - global_irq_enable in control bit 7 gates every enabled source
// - any reset clears global_irq_enable
// - return_from_handler sets global_irq_enable again
// - accepting clears global enable, pushes return address, loads vector 0004h
// - pin and port events reach the vector three to four instruction cycles later
// - flags set on their event regardless of any enable
// - pin edge polarity from ext_edge_select; valid edge sets ext_pin_flag
// - ext_pin_enable clear masks the pin interrupt
// - pin edge wakes from sleep only if its enable was set before sleep
// - timer wrap sets timer_wrap_flag, gated by timer_wrap_enable
// - upper port change sets port_change_flag, gated by port_change_enable
// - nvm write completion sets nvm_write_done_flag, gated by its enable
// - only the return address is saved by hardware
// - enabled interrupt other than the timer wakes from sleep; global enable decides the vector afterwards
module mciu_top (
	input wire logic aclk, // 25 mhz system clock
	input wire logic aresetn, // synchronous reset, active low
	input wire logic [mciu_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [mciu_pkg::DATA_W-1:0] s_axi_wdata, // write data
	input wire logic [mciu_pkg::DATA_W/8-1:0] s_axi_wstrb, // write strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [mciu_pkg::ADDR_W-1:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [mciu_pkg::DATA_W-1:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic ext_irq_pin, // external interrupt pin, asynchronous
	input wire logic [mciu_pkg::PORT_W-1:0] second_io_port_hi, // upper port pins
	input wire logic timer_wrap, // one-cycle pulse when timer_counter_8b wraps
	input wire logic nvm_write_done, // one-cycle pulse at nvm write completion
	input wire mciu_pkg::mciu_core_in_t core_in, // cpu core boundary signals
	output mciu_pkg::mciu_core_out_t core_out, // redirect, push and wake to core
	output logic irq_out // wrapper interrupt, active high level
);
	logic [mciu_pkg::REG_W-1:0] irq_control_reg;
	logic [mciu_pkg::REG_W-1:0] option_reg;
	logic [mciu_pkg::REG_W-1:0] nvm_control_reg;
	logic [mciu_pkg::EVT_W-1:0] irq_status;
	logic [mciu_pkg::EVT_W-1:0] irq_mask;
	mciu_pkg::mciu_state_t state;
	logic ext_en_at_sleep;
	logic wr_en;
	mciu_pkg::mciu_wr_t wr;
	logic wr_hit;
	logic wr_lane;
	logic [mciu_pkg::REG_W-1:0] wr_byte;
	logic [mciu_pkg::DATA_W-1:0] rd_data;
	logic rd_hit;
	logic ext_rise;
	logic ext_fall;
	logic [mciu_pkg::PORT_W-1:0] port_rise;
	logic [mciu_pkg::PORT_W-1:0] port_fall;
	logic ext_edge;
	logic port_change;
	logic [3:0] pending;
	logic irq_request;
	logic wake_any;
	logic accept;
	logic woke;
	logic sleep_nop;
	logic [mciu_pkg::EVT_W-1:0] events;

	mciu_axil_slave u_bus (
		.aclk(aclk),
		.aresetn(aresetn),
		.awaddr(s_axi_awaddr),
		.awvalid(s_axi_awvalid),
		.awready(s_axi_awready),
		.wdata(s_axi_wdata),
		.wstrb(s_axi_wstrb),
		.wvalid(s_axi_wvalid),
		.wready(s_axi_wready),
		.bresp(s_axi_bresp),
		.bvalid(s_axi_bvalid),
		.bready(s_axi_bready),
		.araddr(s_axi_araddr),
		.arvalid(s_axi_arvalid),
		.arready(s_axi_arready),
		.rdata(s_axi_rdata),
		.rresp(s_axi_rresp),
		.rvalid(s_axi_rvalid),
		.rready(s_axi_rready),
		.wr_en(wr_en),
		.wr(wr),
		.wr_hit(wr_hit),
		.rd_data(rd_data),
		.rd_hit(rd_hit)
	);

	// pins pass two flops; a change narrower than a clock cycle
	// may be missed, so the far side holds it longer
	mciu_edge_det #(.W(1)) u_ext_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin(ext_irq_pin),
		.rise(ext_rise),
		.fall(ext_fall)
	);

	mciu_edge_det #(.W(mciu_pkg::PORT_W)) u_port_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin(second_io_port_hi),
		.rise(port_rise),
		.fall(port_fall)
	);

	// edge polarity chosen by ext_edge_select
	assign ext_edge = option_reg[mciu_pkg::BIT_EDGE_SEL] ? ext_rise : ext_fall;
	assign port_change = |(port_rise | port_fall);

	// the four sources, each flag gated by its own enable
	assign pending[0] = irq_control_reg[mciu_pkg::BIT_PORT_FLAG]
		& irq_control_reg[mciu_pkg::BIT_PORT_EN];
	assign pending[1] = irq_control_reg[mciu_pkg::BIT_EXT_FLAG]
		& irq_control_reg[mciu_pkg::BIT_EXT_EN];
	assign pending[2] = irq_control_reg[mciu_pkg::BIT_TIMER_FLAG]
		& irq_control_reg[mciu_pkg::BIT_TIMER_EN];
	assign pending[3] = nvm_control_reg[mciu_pkg::BIT_NVM_FLAG]
		& irq_control_reg[mciu_pkg::BIT_NVM_EN];
	assign irq_request = irq_control_reg[mciu_pkg::BIT_GLOBAL_EN] & (|pending);

	// in sleep the pin source uses the enable captured at sleep entry; the timer
	// is left out because its clock stops while asleep
	assign wake_any = (pending[0] | pending[3]
		| (irq_control_reg[mciu_pkg::BIT_EXT_FLAG] & ext_en_at_sleep));

	assign accept = (state == mciu_pkg::ST_SWITCH) && core_in.cycle_tick && irq_request;
	assign woke = (state == mciu_pkg::ST_SLEEP) && wake_any;
	assign sleep_nop = (state == mciu_pkg::ST_RUN) && core_in.sleep_enter && (|pending);

	// bus decode; registers are at most eight bits, in the low byte lane
	assign wr_lane = wr.strb[0];
	assign wr_byte = wr.data[mciu_pkg::REG_W-1:0];
	assign wr_hit = (wr.addr == mciu_pkg::OFS_IRQ_CONTROL) || (wr.addr == mciu_pkg::OFS_OPTION)
		|| (wr.addr == mciu_pkg::OFS_NVM_CONTROL) || (wr.addr == mciu_pkg::OFS_IRQ_STATUS)
		|| (wr.addr == mciu_pkg::OFS_IRQ_MASK);

	// read mux; core state reads as fsm state, asleep and the pin enable latch
	always_comb
	begin
		rd_data = '0;
		rd_hit = 1'b1;
		case (s_axi_araddr)
			mciu_pkg::OFS_IRQ_CONTROL: rd_data[mciu_pkg::REG_W-1:0] = irq_control_reg;
			mciu_pkg::OFS_OPTION: rd_data[mciu_pkg::REG_W-1:0] = option_reg;
			mciu_pkg::OFS_NVM_CONTROL: rd_data[mciu_pkg::REG_W-1:0] = nvm_control_reg;
			mciu_pkg::OFS_IRQ_STATUS: rd_data[mciu_pkg::EVT_W-1:0] = irq_status;
			mciu_pkg::OFS_IRQ_MASK: rd_data[mciu_pkg::EVT_W-1:0] = irq_mask;
			mciu_pkg::OFS_CORE_STATE: rd_data[3:0] = {ext_en_at_sleep, core_out.asleep, state};
			default: rd_hit = 1'b0;
		endcase
	end

	// irq_control: writes first, then hardware sets, so an event in the clearing
	// cycle survives; flags never clear by themselves
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			irq_control_reg <= mciu_pkg::IRQ_CONTROL_RST;
		else
		begin
			logic [mciu_pkg::REG_W-1:0] next_ctl;
			next_ctl = irq_control_reg;
			if (wr_en && wr_lane && (wr.addr == mciu_pkg::OFS_IRQ_CONTROL))
				next_ctl = wr_byte; // software must clear flags first
			if (core_in.handler_return)
				next_ctl[mciu_pkg::BIT_GLOBAL_EN] = 1'b1;
			if (accept)
				next_ctl[mciu_pkg::BIT_GLOBAL_EN] = 1'b0;
			if (ext_edge)
				next_ctl[mciu_pkg::BIT_EXT_FLAG] = 1'b1;
			if (timer_wrap)
				next_ctl[mciu_pkg::BIT_TIMER_FLAG] = 1'b1;
			if (port_change)
				next_ctl[mciu_pkg::BIT_PORT_FLAG] = 1'b1;
			irq_control_reg <= next_ctl;
		end
	end

	// option and nvm control; only the done flag of nvm control lives here
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			option_reg <= mciu_pkg::OPTION_RST;
			nvm_control_reg <= mciu_pkg::NVM_CONTROL_RST;
		end
		else
		begin
			if (wr_en && wr_lane && (wr.addr == mciu_pkg::OFS_OPTION))
				option_reg <= wr_byte;
			if (nvm_write_done)
				nvm_control_reg[mciu_pkg::BIT_NVM_FLAG] <= 1'b1;
			else if (wr_en && wr_lane && (wr.addr == mciu_pkg::OFS_NVM_CONTROL))
				nvm_control_reg <= wr_byte & mciu_pkg::NVM_CONTROL_MASK;
		end
	end

	// vectoring sequence: a request seen at one instruction boundary is taken two
	// boundaries later, so latency does not depend on instruction length
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			state <= mciu_pkg::ST_RUN;
		else
		begin
			case (state)
				mciu_pkg::ST_RUN:
				begin
					if (core_in.sleep_enter && !(|pending))
						state <= mciu_pkg::ST_SLEEP;
					else if (irq_request && core_in.cycle_tick)
						state <= mciu_pkg::ST_ARMED;
				end
				mciu_pkg::ST_ARMED:
				begin
					if (!irq_request)
						state <= mciu_pkg::ST_RUN;
					else if (core_in.cycle_tick)
						state <= mciu_pkg::ST_SWITCH;
				end
				mciu_pkg::ST_SWITCH:
				begin
					if (!irq_request || core_in.cycle_tick)
						state <= mciu_pkg::ST_RUN;
				end
				mciu_pkg::ST_SLEEP:
				begin
					// wake goes to run; the next instruction runs before any vector
					if (wake_any)
						state <= mciu_pkg::ST_RUN;
				end
				default: state <= mciu_pkg::ST_RUN;
			endcase
		end
	end

	// pin enable captured as sleep is entered
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ext_en_at_sleep <= 1'b0;
		else if ((state == mciu_pkg::ST_RUN) && core_in.sleep_enter)
			ext_en_at_sleep <= irq_control_reg[mciu_pkg::BIT_EXT_EN];
	end

	// core side outputs; only the return address is pushed, nothing else
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			core_out.vector_load <= 1'b0;
			core_out.vector_pc <= mciu_pkg::PC_RST;
			core_out.stack_push <= 1'b0;
			core_out.stack_data <= mciu_pkg::PC_RST;
			core_out.wake <= 1'b0;
			core_out.asleep <= 1'b0;
		end
		else
		begin
			core_out.vector_load <= accept;
			core_out.stack_push <= accept;
			core_out.wake <= woke;
			core_out.asleep <= (state == mciu_pkg::ST_SLEEP) && !wake_any;
			if (accept)
			begin
				core_out.vector_pc <= mciu_pkg::VECTOR_PC;
				core_out.stack_data <= core_in.return_pc;
			end
		end
	end

	assign events[mciu_pkg::EVT_VECTOR] = accept;
	assign events[mciu_pkg::EVT_WAKE] = woke;
	assign events[mciu_pkg::EVT_SLEEP_NOP] = sleep_nop;

	// wrapper status: write one to clear, a same-cycle event wins
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq_status <= mciu_pkg::EVT_RST;
			irq_mask <= mciu_pkg::EVT_RST;
		end
		else
		begin
			if (wr_en && wr_lane && (wr.addr == mciu_pkg::OFS_IRQ_STATUS))
				irq_status <= (irq_status & ~wr_byte[mciu_pkg::EVT_W-1:0]) | events;
			else
				irq_status <= irq_status | events;
			if (wr_en && wr_lane && (wr.addr == mciu_pkg::OFS_IRQ_MASK))
				irq_mask <= wr_byte[mciu_pkg::EVT_W-1:0];
		end
	end

	// registered so the output never glitches on decode
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			irq_out <= 1'b0;
		else
			irq_out <= |(irq_status & irq_mask);
	end
endmodule : mciu_top
`default_nettype wire

// [tb/mciu_core_model.sv]
// behavioural cpu core: instruction ticks, return and sleep requests, program counter
`default_nettype none
module mciu_core_model (
	input wire logic aclk, // system clock
	input wire logic aresetn, // synchronous reset, active low
	input wire logic slow, // 1: tick every 4 clocks, 0: every 2
	input wire logic ret_req, // pulse: execute a return from handler
	input wire logic sleep_req, // pulse: execute a sleep instruction
	input wire mciu_pkg::mciu_core_out_t core_out, // redirect from the unit
	output var mciu_pkg::mciu_core_in_t core_in // boundary signals to the unit
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] phase;
	logic tick;
	logic ret_pend;
	logic sleep_pend;
	logic [mciu_pkg::PC_W-1:0] pc;

	// slow mode mimics a four-phase instruction cycle, fast mode halves it
	assign tick = slow ? (phase == 2'h3) : phase[0];

	// free-running instruction phase
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			phase <= 2'h0;
		else
			phase <= phase + 2'h1;
	end

	// requests wait for the next boundary; pc frozen in sleep, jumps on redirect
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ret_pend <= 1'b0;
			sleep_pend <= 1'b0;
			pc <= mciu_pkg::PC_RST;
		end
		else
		begin
			ret_pend <= ret_req | (ret_pend & ~tick);
			sleep_pend <= sleep_req | (sleep_pend & ~tick);
			if (core_out.vector_load)
				pc <= core_out.vector_pc;
			else if (tick && !core_out.asleep)
				pc <= pc + 13'h0001;
		end
	end

	// return is only requested by the bench after the flags are cleared
	always_comb
		core_in = '{cycle_tick: tick, handler_return: ret_pend & tick,
			sleep_enter: sleep_pend & tick, return_pc: pc};
endmodule : mciu_core_model
`default_nettype wire

// [tb/mciu_top_checker.sv]
// port-level assertion checker for the interrupt unit
`default_nettype none
module mciu_top_checker (
	input wire logic aclk, // system clock
	input wire logic aresetn, // synchronous reset, active low
	input wire mciu_pkg::mciu_core_in_t core_in, // core boundary signals
	input wire mciu_pkg::mciu_core_out_t core_out, // redirect, push and wake
	input wire logic irq_out // wrapper interrupt level
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// an accept pushes and redirects to the fixed vector in the same cycle
	AST_PUSH_VECTOR: assert property (
		core_out.vector_load |-> core_out.stack_push && core_out.vector_pc == mciu_pkg::VECTOR_PC)
		else $error("vector load without push or wrong vector");
	// redirect is a single pulse, a second one would enter the handler twice
	AST_VECTOR_PULSE: assert property (
		core_out.vector_load |=> !core_out.vector_load && !core_out.stack_push)
		else $error("vector load longer than one cycle");
	// only the return address is handed over, taken at the accepting edge
	AST_RETURN_PC: assert property (
		core_out.vector_load |-> core_out.stack_data == $past(core_in.return_pc))
		else $error("pushed address differs from return address");
	// pushed address stays until the next accept
	AST_STACK_HOLD: assert property (
		!core_out.vector_load |-> $stable(core_out.stack_data))
		else $error("pushed address changed without accept");
	// accept only happens on an instruction boundary
	AST_ON_TICK: assert property (
		core_out.vector_load |-> $past(core_in.cycle_tick))
		else $error("vector load not after an instruction boundary");
	// no redirect while the core sleeps; the next instruction runs first
	AST_NO_VECTOR_ASLEEP: assert property (
		core_out.asleep |-> !core_out.vector_load)
		else $error("vector load while asleep");
	// wake only comes out of sleep and lasts one cycle
	AST_WAKE_FROM_SLEEP: assert property (
		core_out.wake |-> $past(core_out.asleep) ##1 !core_out.wake)
		else $error("wake without sleep or wake too long");
	// reset leaves no request, no sleep and no redirect behind
	AST_RESET_QUIET: assert property (
		$rose(aresetn) |-> !core_out.vector_load && !core_out.asleep && !irq_out)
		else $error("outputs active just after reset");

	COV_VECTOR: cover property (core_out.vector_load);
	COV_WAKE: cover property (core_out.wake);
	COV_IRQ: cover property (irq_out);
endmodule : mciu_top_checker

bind mciu_top mciu_top_checker u_checker (.aclk, .aresetn, .core_in, .core_out, .irq_out);
`default_nettype wire

// [tb/mciu_top_tb.sv]
// self-checking bench for the interrupt unit over its register bus and core link
`default_nettype none
module mciu_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h00000000;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic ext_irq_pin = 1'b0, timer_wrap = 1'b0, nvm_write_done = 1'b0;
	logic [3:0] second_io_port_hi = 4'h0;
	logic slow = 1'b1, ret_req = 1'b0, sleep_req = 1'b0;
	mciu_pkg::mciu_core_in_t core_in;
	mciu_pkg::mciu_core_out_t core_out;
	logic irq_out;
	logic [1:0] rsp;
	int n_mismatch = 0, compares = 0, vcnt = 0, cyc = 0, t = 0;
	localparam logic [7:0] CTL = mciu_pkg::OFS_IRQ_CONTROL, NVM = mciu_pkg::OFS_NVM_CONTROL;

	mciu_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_irq_pin,
		.second_io_port_hi, .timer_wrap, .nvm_write_done, .core_in, .core_out, .irq_out);
	mciu_core_model u_core (.aclk, .aresetn, .slow, .ret_req, .sleep_req, .core_out, .core_in);

	always #20 aclk = ~aclk;
	// redirects counted off the sampling edge, clear of update races
	always @(negedge aclk)
		if (core_out.vector_load === 1'b1) vcnt++;
	// hang guard, well above the run's length
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_mismatch++;
			end_sim();
		end
	end

	task automatic end_sim();
		if (n_mismatch == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk

	// write: both channels offered together, each released once taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ka, kw, kb;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(negedge aclk);
			ka = s_axi_awready;
			kw = s_axi_wready;
			kb = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ka) s_axi_awvalid <= 1'b0;
			if (kw) s_axi_wvalid <= 1'b0;
		end while (!kb);
		s_axi_bready <= 1'b0;
	endtask : axw

	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ka, kr;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(negedge aclk);
			ka = s_axi_arready;
			kr = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ka) s_axi_arvalid <= 1'b0;
		end while (!kr);
		s_axi_rready <= 1'b0;
	endtask : axr

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [1:0] r;
		axw(a, {24'h000000, d}, r);
	endtask : wr

	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		logic [31:0] d;
		logic [1:0] r;
		axr(a, d, r);
		chk({30'h0, r}, {30'h0, mciu_pkg::RESP_OKAY});
		chk(d, {24'h000000, e});
	endtask : rc

	// let outputs settle before looking at them
	task automatic settle(input int n);
		repeat (n) @(posedge aclk);
		@(negedge aclk);
	endtask : settle

	// source event: 0 port change, 1 pin toggle, 2 timer wrap, 3 nvm done
	task automatic ev(input int s);
		@(posedge aclk);
		case (s)
			0: second_io_port_hi <= second_io_port_hi ^ 4'h1;
			1: ext_irq_pin <= ~ext_irq_pin;
			2: timer_wrap <= 1'b1;
			default: nvm_write_done <= 1'b1;
		endcase
		@(posedge aclk);
		timer_wrap <= 1'b0;
		nvm_write_done <= 1'b0;
	endtask : ev

	task automatic pulse_req(input logic is_sleep);
		@(posedge aclk);
		sleep_req <= is_sleep;
		ret_req <= !is_sleep;
		@(posedge aclk);
		sleep_req <= 1'b0;
		ret_req <= 1'b0;
		settle(12);
	endtask : pulse_req

	// instruction ticks until the redirect, bounded
	task automatic wv(output int n);
		n = 0;
		do
		begin
			@(negedge aclk);
			if (core_in.cycle_tick === 1'b1) n++;
		end while (core_out.vector_load !== 1'b1 && n < 40);
	endtask : wv

	initial
	begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		settle(4);
		rc(CTL, 8'h00);
		rc(mciu_pkg::OFS_OPTION, 8'hFF);
		rc(NVM, 8'h00);
		axw(8'h18, 32'h000000FF, rsp);
		chk({30'h0, rsp}, {30'h0, mciu_pkg::RESP_SLVERR});
		// all sources flag with every enable off; no vector
		for (int s = 0; s < 4; s++) ev(s);
		settle(8);
		rc(CTL, 8'h07);
		rc(NVM, 8'h10);
		chk(vcnt, 0);
		wr(CTL, 8'h00);
		wr(NVM, 8'h00);
		// falling edge selected: fall flags, rise does not
		wr(mciu_pkg::OFS_OPTION, 8'hBF);
		ev(1);
		settle(6);
		rc(CTL, 8'h02);
		wr(CTL, 8'h00);
		ev(1);
		settle(6);
		rc(CTL, 8'h00);
		// pin enable off masks the pin
		wr(CTL, 8'hE8);
		ev(1);
		settle(40);
		chk(vcnt, 0);
		rc(CTL, 8'hEA);
		wr(CTL, 8'h00);
		wr(mciu_pkg::OFS_OPTION, 8'hFF);
		// each source through accept, handler and return
		for (int s = 0; s < 4; s++)
		begin
			slow <= (s != 3);
			wr(CTL, 8'h80 | (8'h08 << s));
			repeat (s) @(posedge aclk);
			ev(s);
			wv(t);
			if (s < 2) chk(32'(t >= 3 && t <= 4), 1);
			chk(32'(core_out.vector_pc), 32'(mciu_pkg::VECTOR_PC));
			rc(CTL, (8'h08 << s) | ((s < 3) ? (8'h01 << s) : 8'h00));
			wr(CTL, 8'h08 << s);
			wr(NVM, 8'h00);
			pulse_req(1'b0);
			rc(CTL, 8'h80 | (8'h08 << s));
			chk(vcnt, s + 1);
		end
		slow <= 1'b1;
		// pin edge wakes only if its enable was set before sleep
		wr(CTL, 8'h00);
		pulse_req(1'b1);
		ev(1);
		settle(8);
		ev(1);
		settle(20);
		chk(32'(core_out.asleep), 1);
		wr(CTL, 8'h12);
		settle(20);
		chk(32'(core_out.asleep), 1);
		wr(CTL, 8'h1A);
		ev(0);
		settle(20);
		chk(32'(core_out.asleep), 0);
		chk(vcnt, 4);
		// global enable set: wake, then the redirect follows
		wr(CTL, 8'h88);
		pulse_req(1'b1);
		chk(32'(core_out.asleep), 1);
		rc(mciu_pkg::OFS_CORE_STATE, 8'h06);
		ev(0);
		wv(t);
		chk(32'(t < 40), 1);
		// sleep with an enabled flag pending is a no operation
		pulse_req(1'b1);
		chk(32'(core_out.asleep), 0);
		rc(mciu_pkg::OFS_IRQ_STATUS, 8'h07);
		chk(32'(irq_out), 0);
		wr(mciu_pkg::OFS_IRQ_MASK, 8'h04);
		settle(2);
		chk(32'(irq_out), 1);
		wr(mciu_pkg::OFS_IRQ_STATUS, 8'h04);
		settle(2);
		chk(32'(irq_out), 0);
		rc(mciu_pkg::OFS_IRQ_STATUS, 8'h03);
		end_sim();
	end
endmodule : mciu_top_tb
`default_nettype wire
